/* src/adc_back_end.sv */
// digital back end of the converter: calibration sequencing, correction and code formatting
`timescale 1ns/100ps
// What this block does
// R1 - signed format: zero is all zeros, 0111 top
// R2 - signed format: top bit set means negative
// R3 - offset format: zeros bottom, 1000 mid, ones top
// R4 - offset format: top bit set means non-negative
// R5 - background calibration runs on fixed schedule
// R6 - store calibration results, use for later conversions
// R7 - subtract stored offset from every conversion
// R8 - divide every conversion by stored gain
// R9 - self-calibration command disconnects input, recalibrates
// R10 - hold results and flag busy while calibrating
module adc_back_end #(
  parameter int DATA_W = adc_cal_pkg::DATA_W_DEF,
  parameter int REF_IDEAL = adc_cal_pkg::REF_IDEAL_DEF,
  parameter int BG_INTERVAL = adc_cal_pkg::BG_INTERVAL_DEF
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic RAW_VALID,
  input wire logic [DATA_W-1:0] RAW_CODE,
  input wire logic FORMAT_SEL,
  input wire logic SELF_CAL_REQ,
  input wire logic CAL_SAMPLE_VALID,
  input wire logic [DATA_W-1:0] CAL_SAMPLE,
  output logic INPUT_CONNECT,
  output logic CAL_REF_SEL,
  output logic BUSY,
  output logic CAL_DONE,
  output logic OUT_VALID,
  output logic [DATA_W-1:0] OUT_CODE
);

  // ---------------------------------------------------------------
  // widths and limits
  // ---------------------------------------------------------------
  localparam int NW = 2 * DATA_W + 1;
  localparam logic signed [NW-1:0] QMAX = {{(NW-DATA_W+1){1'b0}}, {(DATA_W-1){1'b1}}};
  localparam logic signed [NW-1:0] QMIN = ~QMAX;
  localparam logic [31:0] BG_LAST = 32'(BG_INTERVAL - 1);

  typedef struct packed {
    adc_cal_pkg::cal_state_type st;
    logic cal_pend;
    logic [31:0] bg_cnt;
    logic signed [DATA_W-1:0] ofs;
    logic [DATA_W-1:0] gain;
    logic fmt;
    logic div_start;
    logic signed [NW-1:0] div_num;
    logic signed [DATA_W-1:0] res;
    logic [DATA_W-1:0] out_code;
    logic out_valid;
    logic conn;
    logic ref_sel;
    logic busy;
    logic done;
  } back_state_type;

  back_state_type s_r;
  back_state_type s_nxt;

  div_if #(.NW(NW), .DW(DATA_W)) dv ();

  gain_divider #(.NW(NW), .DW(DATA_W)) u_div (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .dv(dv.rsp)
  );

  assign dv.start = s_r.div_start;
  assign dv.num = s_r.div_num;
  assign dv.den = s_r.gain;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic signed [NW-1:0] diff_x;
  logic signed [NW-1:0] prod_x;
  logic signed [DATA_W-1:0] sat_q;
  logic signed [DATA_W:0] span_x;
  logic bg_tick;

  // offset removed first, then scaled by the ideal reference reading
  assign diff_x = NW'(signed'(RAW_CODE)) - NW'(s_r.ofs); // [R7]
  assign prod_x = NW'(diff_x * NW'(REF_IDEAL));
  // gain value is the reference reading with the fresh offset taken off
  assign span_x = (DATA_W+1)'(signed'(CAL_SAMPLE)) - (DATA_W+1)'(s_r.ofs);
  assign bg_tick = (s_r.bg_cnt == BG_LAST);

  // clamp the quotient to the code range instead of wrapping it
  always_comb begin
    if (dv.quo > QMAX) begin
      sat_q = DATA_W'(QMAX);
    end else if (dv.quo < QMIN) begin
      sat_q = DATA_W'(QMIN);
    end else begin
      sat_q = DATA_W'(dv.quo); // [R8]
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // one conversion in flight at a time; raw codes offered while busy are dropped
  always_comb begin
    s_nxt = s_r;
    s_nxt.out_valid = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.div_start = 1'b0;
    // free-running schedule, independent of traffic
    s_nxt.bg_cnt = bg_tick ? '0 : s_r.bg_cnt + 32'd1; // [R5]
    unique case (s_r.st)
      adc_cal_pkg::ST_RUN: begin
        if (s_r.cal_pend) begin
          s_nxt.cal_pend = 1'b0;
          s_nxt.conn = 1'b0; // [R9]
          s_nxt.ref_sel = 1'b0;
          s_nxt.busy = 1'b1; // [R10]
          s_nxt.st = adc_cal_pkg::ST_CAL_OFS;
        end else if (RAW_VALID) begin
          s_nxt.fmt = FORMAT_SEL;
          s_nxt.div_num = prod_x; // [R6]
          s_nxt.div_start = 1'b1;
          s_nxt.st = adc_cal_pkg::ST_DIV;
        end
      end
      adc_cal_pkg::ST_DIV: begin
        if (dv.done) begin
          s_nxt.res = sat_q;
          if (s_r.fmt == adc_cal_pkg::FMT_OFFSET) begin
            s_nxt.out_code = {~sat_q[DATA_W-1], sat_q[DATA_W-2:0]}; // [R3] [R4]
          end else begin
            s_nxt.out_code = sat_q; // [R1] [R2]
          end
          s_nxt.out_valid = 1'b1;
          s_nxt.st = adc_cal_pkg::ST_RUN;
        end
      end
      adc_cal_pkg::ST_CAL_OFS: begin
        // input shorted internally: the reading is the offset itself
        if (CAL_SAMPLE_VALID) begin
          s_nxt.ofs = signed'(CAL_SAMPLE); // [R6]
          s_nxt.ref_sel = 1'b1;
          s_nxt.st = adc_cal_pkg::ST_CAL_GAIN;
        end
      end
      adc_cal_pkg::ST_CAL_GAIN: begin
        if (CAL_SAMPLE_VALID) begin
          // a non-positive span would make the divide meaningless; keep the old gain
          if (span_x > 0) begin
            s_nxt.gain = DATA_W'(span_x); // [R6]
          end
          s_nxt.ref_sel = 1'b0;
          s_nxt.conn = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.st = adc_cal_pkg::ST_RUN;
        end
      end
    endcase
    // a request in the cycle the pending flag is cleared still counts
    s_nxt.cal_pend = s_nxt.cal_pend | SELF_CAL_REQ | bg_tick; // [R5] [R9]
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.ofs <= DATA_W'(adc_cal_pkg::OFFSET_RST);
      s_r.gain <= DATA_W'(REF_IDEAL);
      s_r.conn <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign INPUT_CONNECT = s_r.conn;
  assign CAL_REF_SEL = s_r.ref_sel;
  assign BUSY = s_r.busy;
  assign CAL_DONE = s_r.done;
  assign OUT_VALID = s_r.out_valid;
  assign OUT_CODE = s_r.out_code;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_answer;
    (s_r.st == adc_cal_pkg::ST_DIV) && dv.done;
  endsequence

  sequence s_cal_entered;
    ##[1:40] (!INPUT_CONNECT && BUSY);
  endsequence

  property p_signed_zero;
    s_answer and (s_r.fmt == adc_cal_pkg::FMT_SIGNED) && (dv.quo == '0) |=> OUT_VALID && (OUT_CODE == '0);
  endproperty
  a_signed_zero: assert property (p_signed_zero) else $error("signed zero not all zeros"); // [R1]

  property p_signed_sign;
    s_answer and (s_r.fmt == adc_cal_pkg::FMT_SIGNED) |=> OUT_CODE[DATA_W-1] == $past(dv.quo[NW-1]);
  endproperty
  a_signed_sign: assert property (p_signed_sign) else $error("signed top bit not the sign"); // [R2]

  property p_offset_zero;
    s_answer and (s_r.fmt == adc_cal_pkg::FMT_OFFSET) && (dv.quo == '0)
      |=> OUT_CODE == {1'b1, {(DATA_W-1){1'b0}}};
  endproperty
  a_offset_zero: assert property (p_offset_zero) else $error("offset zero not at mid code"); // [R3]

  property p_offset_sign;
    s_answer and (s_r.fmt == adc_cal_pkg::FMT_OFFSET) |=> OUT_CODE[DATA_W-1] == !$past(dv.quo[NW-1]);
  endproperty
  a_offset_sign: assert property (p_offset_sign) else $error("offset top bit wrong"); // [R4]

  property p_bg_cal;
    bg_tick |-> s_cal_entered;
  endproperty
  a_bg_cal: assert property (p_bg_cal) else $error("scheduled calibration did not start"); // [R5]

  property p_ofs_store;
    (s_r.st == adc_cal_pkg::ST_CAL_OFS) && CAL_SAMPLE_VALID |=> ##1 (s_r.ofs == $past(CAL_SAMPLE, 2));
  endproperty
  a_ofs_store: assert property (p_ofs_store) else $error("offset value not stored"); // [R6]

  property p_correct;
    (s_r.st == adc_cal_pkg::ST_RUN) && !s_r.cal_pend && RAW_VALID
      |=> dv.start && (dv.num == NW'((NW'(signed'($past(RAW_CODE))) - NW'(s_r.ofs)) * NW'(REF_IDEAL)));
  endproperty
  a_correct: assert property (p_correct) else $error("offset not removed before divide"); // [R7]

  property p_scale;
    s_answer and (dv.quo <= QMAX) && (dv.quo >= QMIN) |=> s_r.res == DATA_W'($past(dv.quo));
  endproperty
  a_scale: assert property (p_scale) else $error("quotient not delivered"); // [R8]

  property p_self_cal;
    SELF_CAL_REQ |-> s_cal_entered;
  endproperty
  a_self_cal: assert property (p_self_cal) else $error("self calibration did not start"); // [R9]

  property p_hold_busy;
    !INPUT_CONNECT |-> BUSY && !OUT_VALID;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("result given during calibration"); // [R10]

endmodule // adc_back_end

/* src/adc_cal_pkg.sv */
// constants and types used by the converter back end and its bench
package adc_cal_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int DATA_W_DEF = 16;          // output code width
  localparam int REF_IDEAL_DEF = 16384;    // ideal reading of the internal reference
  localparam int BG_INTERVAL_DEF = 100000; // cycles between background calibrations

  // ---------------------------------------------------------------
  // reset values and code formats
  // ---------------------------------------------------------------
  localparam int OFFSET_RST = 0;            // offset correction after reset
  localparam logic FMT_SIGNED = 1'b0;       // signed_code_format
  localparam logic FMT_OFFSET = 1'b1;       // offset_code_format

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_DIV,
    ST_CAL_OFS,
    ST_CAL_GAIN
  } cal_state_type;

endpackage

/* src/div_if.sv */
// request and answer signals between the back end and its gain divider
`timescale 1ns/100ps
interface div_if #(
  parameter int NW = 33,
  parameter int DW = 16
);
  logic start;
  logic signed [NW-1:0] num;
  logic [DW-1:0] den;
  logic done;
  logic signed [NW-1:0] quo;

  modport req (output start, output num, output den, input done, input quo);
  modport rsp (input start, input num, input den, output done, output quo);
endinterface

/* src/gain_divider.sv */
// iterative signed-by-positive divider used for the gain correction
`timescale 1ns/100ps
module gain_divider #(
  parameter int NW = 33,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  div_if.rsp dv
);

  localparam int CW = $clog2(NW + 1);

  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
    logic neg;
    logic [DW-1:0] den;
    logic [DW-1:0] rem;
    logic [NW-1:0] q;
    logic done;
    logic signed [NW-1:0] quo;
  } div_state_type;

  div_state_type s_r;
  div_state_type s_nxt;

  // ---------------------------------------------------------------
  // restoring division on magnitudes, one quotient bit per cycle
  // ---------------------------------------------------------------
  // the sign is restored at the end, so rounding is toward zero
  always_comb begin
    logic [DW:0] trial;
    trial = '0;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy && dv.start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = CW'(NW);
      s_nxt.neg = dv.num[NW-1];
      s_nxt.q = dv.num[NW-1] ? NW'(-dv.num) : NW'(dv.num);
      s_nxt.den = dv.den;
      s_nxt.rem = '0;
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.quo = s_r.neg ? -signed'(s_r.q) : signed'(s_r.q);
      end else begin
        trial = {s_r.rem, s_r.q[NW-1]};
        s_nxt.q = {s_r.q[NW-2:0], 1'b0};
        if (trial >= {1'b0, s_r.den}) begin
          s_nxt.rem = DW'(trial - {1'b0, s_r.den});
          s_nxt.q[0] = 1'b1;
        end else begin
          s_nxt.rem = DW'(trial);
        end
        s_nxt.cnt = s_r.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dv.done = s_r.done;
  assign dv.quo = s_r.quo;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_div_answers;
    @(posedge clk) disable iff (!rst_n)
    (dv.start && !s_r.busy) |-> ##[2:40] dv.done;
  endproperty
  a_div_answers: assert property (p_div_answers) else $error("divider gave no answer in time"); // [R8]

endmodule // gain_divider

/* tb/cal_host_model.sv */
// host-side model that supplies readings during a calibration
`timescale 1ns/100ps
module cal_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic connect,
  input wire logic ref_sel,
  input wire logic [15:0] ofs_val,
  input wire logic [15:0] ref_val,
  input wire logic [3:0] lag,
  output logic sample_valid,
  output logic [15:0] sample
);
  // zero reading first, reference reading second; idle bus shows the inverse so stale data never matches
  initial begin
    sample_valid = 1'b0;
    sample = 16'h0000;
    forever begin
      @(negedge clk);
      if (rst_n && !connect) begin
        repeat (lag) @(negedge clk);
        sample_valid = 1'b1;
        sample = ofs_val;
        @(negedge clk);
        sample_valid = 1'b0;
        sample = ~ofs_val;
        // let an edge pass so valid never falls and rises in one step; bounded so a stuck select cannot hang here
        @(negedge clk);
        for (int i = 0; i < 400 && !ref_sel; i++) @(negedge clk);
        repeat (lag) @(negedge clk);
        sample_valid = 1'b1;
        sample = ref_val;
        @(negedge clk);
        sample_valid = 1'b0;
        sample = ~ref_val;
        for (int i = 0; i < 400 && !connect; i++) @(negedge clk);
      end
    end
  end
endmodule // cal_host_model

/* tb/tb_adc_back_end.sv */
// self-checking bench for the converter back end
`timescale 1ns/100ps
module tb_adc_back_end;
  logic sys_clk, rst_n, raw_valid, format_sel, self_cal_req, cal_sample_valid;
  logic input_connect, cal_ref_sel, busy, cal_done, out_valid;
  logic [15:0] raw_code, cal_sample, out_code, ofs_val, ref_val;
  logic [3:0] lag;
  int failures, samples_checked;

  // short background interval keeps the run brief
  adc_back_end #(.BG_INTERVAL(200)) u_dut (
    .SYS_CLK(sys_clk),
    .RST_N(rst_n),
    .RAW_VALID(raw_valid),
    .RAW_CODE(raw_code),
    .FORMAT_SEL(format_sel),
    .SELF_CAL_REQ(self_cal_req),
    .CAL_SAMPLE_VALID(cal_sample_valid),
    .CAL_SAMPLE(cal_sample),
    .INPUT_CONNECT(input_connect),
    .CAL_REF_SEL(cal_ref_sel),
    .BUSY(busy),
    .CAL_DONE(cal_done),
    .OUT_VALID(out_valid),
    .OUT_CODE(out_code)
  );

  cal_host_model u_host (
    .clk(sys_clk),
    .rst_n(rst_n),
    .connect(input_connect),
    .ref_sel(cal_ref_sel),
    .ofs_val(ofs_val),
    .ref_val(ref_val),
    .lag(lag),
    .sample_valid(cal_sample_valid),
    .sample(cal_sample)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  // 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // 0 busy high, 1 done pulse, 2 result pulse, 3 busy low; bounded so a hang ends the run
  task wait_sig(input int sel);
    int n;
    n = 0;
    while (!((sel == 0 && busy === 1'b1) || (sel == 1 && cal_done === 1'b1) ||
             (sel == 2 && out_valid === 1'b1) || (sel == 3 && busy === 1'b0))) begin
      @(negedge sys_clk);
      n++;
      if (n > 400) begin
        failures++;
        $display("timeout waiting on event %0d", sel);
        report_and_stop;
      end
    end
  endtask

  // request held as a level until the result pulse, so a pending calibration cannot swallow it
  task convert(input logic [15:0] code, input logic fmt, input logic [15:0] exp);
    raw_code = code;
    format_sel = fmt;
    raw_valid = 1'b1;
    @(negedge sys_clk);
    wait_sig(2);
    raw_valid = 1'b0;
    check(out_code, exp);
    @(negedge sys_clk);
    check({15'h0000, out_valid}, 16'h0000);
  endtask

  task self_cal;
    wait_sig(3);
    self_cal_req = 1'b1;
    @(negedge sys_clk);
    self_cal_req = 1'b0;
    wait_sig(0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    check({11'h000, input_connect, cal_ref_sel, busy, cal_done, out_valid}, 16'h0010);
    check(out_code, 16'h0000);
    $display("test reset done");
  endtask

  task t_codes;
    logic [15:0] codes [5];
    codes = '{16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'hffff};
    for (int i = 0; i < 5; i++) begin
      convert(codes[i], adc_cal_pkg::FMT_SIGNED, codes[i]);
      convert(codes[i], adc_cal_pkg::FMT_OFFSET, codes[i] ^ 16'h8000);
    end
    $display("test codes done");
  endtask

  task t_self_cal;
    ofs_val = 16'h0010;
    ref_val = 16'h2010;
    self_cal;
    check({14'h0000, input_connect, cal_ref_sel}, 16'h0000);
    @(negedge sys_clk);
    check({14'h0000, input_connect, cal_ref_sel}, 16'h0001);
    wait_sig(1);
    check({13'h0000, input_connect, busy, cal_ref_sel}, 16'h0004);
    @(negedge sys_clk);
    convert(16'h0110, adc_cal_pkg::FMT_SIGNED, 16'h0200);
    convert(16'hff10, adc_cal_pkg::FMT_SIGNED, 16'hfe00);
    convert(16'h7000, adc_cal_pkg::FMT_SIGNED, 16'h7fff);
    convert(16'h8000, adc_cal_pkg::FMT_SIGNED, 16'h8000);
    convert(16'h0110, adc_cal_pkg::FMT_OFFSET, 16'h8200);
    convert(16'h0010, adc_cal_pkg::FMT_OFFSET, 16'h8000);
    $display("test self calibration done");
  endtask

  // a slow host stretches the calibration; a raw code offered meanwhile must be dropped
  task t_refused;
    int pulses;
    pulses = 0;
    lag = 4'h5;
    self_cal;
    raw_code = 16'h0020;
    raw_valid = 1'b1;
    @(negedge sys_clk);
    raw_valid = 1'b0;
    repeat (60) begin
      @(negedge sys_clk);
      if (out_valid === 1'b1) pulses++;
    end
    check(pulses[15:0], 16'h0000);
    $display("test refused done");
  endtask

  task t_background;
    ofs_val = 16'h0000;
    ref_val = 16'h4000;
    lag = 4'h0;
    wait_sig(3);
    wait_sig(0);
    check({15'h0000, input_connect}, 16'h0000);
    wait_sig(1);
    @(negedge sys_clk);
    convert(16'h1234, adc_cal_pkg::FMT_SIGNED, 16'h1234);
    // reference below the offset: the new offset is stored but the unity gain is kept
    ofs_val = 16'h0100;
    ref_val = 16'h0080;
    self_cal;
    wait_sig(1);
    @(negedge sys_clk);
    convert(16'h0300, adc_cal_pkg::FMT_SIGNED, 16'h0200);
    $display("test background done");
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    raw_valid = 1'b0;
    raw_code = 16'h0000;
    format_sel = 1'b0;
    self_cal_req = 1'b0;
    ofs_val = 16'h0000;
    ref_val = 16'h4000;
    lag = 4'h0;
    failures = 0;
    samples_checked = 0;
    repeat (6) @(negedge sys_clk);
    t_reset;
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_codes;
    t_self_cal;
    t_refused;
    t_background;
    report_and_stop;
  end
endmodule // tb_adc_back_end
